/* File: core/fram_status_protect_pkg.sv */
package fram_status_protect_pkg;

   // Command opcodes seen on the serial link
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_SPECIAL_SECTOR_WRITE = 8'h42;
   localparam logic [7:0] OP_ANY_REG_WRITE = 8'h71;
   localparam logic [7:0] OP_SERIAL_NUMBER_WRITE = 8'hC2;
   localparam logic [7:0] OP_STATUS_ONE_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_TWO_READ = 8'h07;
   localparam logic [7:0] OP_ANY_REG_READ = 8'h65;
   localparam logic [7:0] OP_MEMORY_WRITE = 8'h02;
   localparam logic [7:0] OP_CRC_CALCULATE = 8'h5B;
   localparam logic [7:0] OP_CRC_SUSPEND = 8'hB0;
   localparam logic [7:0] OP_CRC_RESUME = 8'h30;
   localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;

   // Frame lengths in link clock bits
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_OP_BYTE = 6'h10;
   localparam logic [5:0] BITS_OP_ADDR = 6'h20;
   localparam logic [5:0] BITS_OP_ADDR_BYTE = 6'h28;
   localparam logic [5:0] BITS_FRAME = 6'h38;

   // Status register field positions
   localparam int SR1_LOCK_BIT = 7;
   localparam int SR1_ORIGIN_BIT = 5;
   localparam int SR1_BP_LSB = 2;
   localparam int SR1_WEL_BIT = 1;
   localparam int SR1_BUSY_BIT = 0;
   localparam int SR2_SUSPEND_BIT = 4;
   localparam int SR2_ABORT_BIT = 3;
   localparam logic [7:0] SR1_WRITABLE_MASK = 8'hBC;

   // Register address map: space byte, then register offset byte
   localparam logic [7:0] REG_SPACE_NV = 8'h00;
   localparam logic [7:0] REG_SPACE_VOL = 8'h07;
   localparam logic [7:0] REG_SR1 = 8'h00;
   localparam logic [7:0] REG_SR2 = 8'h01;
   localparam logic [7:0] REG_CR1 = 8'h02;
   localparam logic [7:0] REG_CR2 = 8'h03;
   localparam logic [7:0] REG_CR4 = 8'h05;
   localparam logic [7:0] REG_CR5 = 8'h06;
   localparam logic [7:0] REG_LAST = 8'h06;
   localparam int SLOTS = 5;
   localparam logic [39:0] SLOT_OFFSET = {REG_CR5, REG_CR4, REG_CR2, REG_CR1, REG_SR1};

   // Reset (factory) values of the shadowed registers
   localparam logic [7:0] SR1_RESET = 8'h00;
   localparam logic [7:0] CR1_RESET = 8'h00;
   localparam logic [7:0] CR2_RESET = 8'h00;
   localparam logic [7:0] CR4_RESET = 8'h00;
   localparam logic [7:0] CR5_RESET = 8'h00;
   localparam logic [39:0] SLOT_RESET = {CR5_RESET, CR4_RESET, CR2_RESET, CR1_RESET, SR1_RESET};

   // Array geometry and CRC range check
   localparam logic [19:0] ARRAY_BYTES = 20'h80000;
   localparam logic [24:0] CRC_MIN_SPAN = 25'h0000003;

   // CRC sequencer states, one-hot
   localparam int CRC_RUN_BIT = 1;
   localparam int CRC_SUSPEND_BIT = 2;
   typedef enum logic [2:0] {
      CRC_IDLE = 3'b001,
      CRC_RUN = 3'b010,
      CRC_SUSPEND = 3'b100
   } crc_state_t;

endpackage

/* File: core/fram_status_protect_regs.sv */
`timescale 1ns/1ps

// What this block does
// - Block array writes inside the protected range
// - Code picks none, fractions, or whole array
// - Origin bit selects top or bottom range
// - No array or register write without latch
// - Only write-enable command sets the latch
// - Listed opcodes clear latch at frame end
// - Array writes leave the latch set
// - Latch volatile, cleared by every reset
// - Lock bit with pin low freezes registers
// - Busy only while CRC calculation runs
// - While busy accept reads, suspend, reset only
// - Second status register read-only at two addresses
// - Suspend sets, resume clears suspended flag
// - Suspended flag cleared by every reset
// - Abort CRC when end below start plus three
// - Abort flag cleared by good start, resets
// - Volatile and non-volatile config copies, reloaded
// - Behaviour uses only volatile config copies
// - Volatile write one copy, non-volatile both
// - Reads always return the volatile copy
module fram_status_protect_regs (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic wp_n,
   input wire logic hw_reset_n,
   input wire logic crc_done,
   output logic mem_wr_valid,
   output logic [18:0] mem_wr_addr,
   output logic [7:0] mem_wr_data,
   output logic crc_start,
   output logic crc_run,
   output logic crc_suspend,
   output logic [23:0] crc_start_addr,
   output logic [23:0] crc_end_addr,
   output logic [31:0] config_active
);

   // Register address is valid in either space, offset inside the map
   function automatic logic reg_addr_ok(input logic [23:0] a);
      reg_addr_ok = ((a[23:16] == fram_status_protect_pkg::REG_SPACE_NV) ||
                     (a[23:16] == fram_status_protect_pkg::REG_SPACE_VOL)) &&
                    (a[15:8] == 8'h00) && (a[7:0] <= fram_status_protect_pkg::REG_LAST);
   endfunction

   // Range check of an array address against the block-protect code
   function automatic logic block_protected(input logic [18:0] a, input logic [2:0] bp,
                                            input logic origin);
      logic [19:0] span;
      span = fram_status_protect_pkg::ARRAY_BYTES >> (3'h7 - bp);
      if (bp == 3'h0) begin
         block_protected = 1'b0;
      end else if (origin) begin
         block_protected = ({1'b0, a} < span);
      end else begin
         block_protected = ({1'b0, a} >= (fram_status_protect_pkg::ARRAY_BYTES - span));
      end
   endfunction

   // ---------------- Link domain (sck) ----------------
   logic [55:0] frame_bits; // Bits of the frame, opcode at the top
   logic [5:0] bit_cnt; // Bits taken so far, saturates at a full frame
   logic [2:0] bit_phase; // Position inside the current byte
   logic [7:0] snap_reg [0:6]; // Register image, frozen while a frame is open
   logic [7:0] rd_byte; // Byte the link is sending back
   logic send_now; // Read command has reached its data phase
   logic [7:0] link_op;
   logic [5:0] frame_len_reg; // Length of the last frame, kept after chip select rises

   assign link_op = frame_bits[55:48];

   // Counters restart with each frame; chip select is the frame's own end
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt <= 6'h00;
         bit_phase <= 3'h0;
      end else begin
         bit_phase <= bit_phase + 3'h1;
         if (bit_cnt != fram_status_protect_pkg::BITS_FRAME) begin
            bit_cnt <= bit_cnt + 6'h01;
         end
      end
   end

   // Bits land at fixed positions so short frames keep the opcode aligned
   always_ff @(posedge sck) begin
      if (!cs_n && (bit_cnt != fram_status_protect_pkg::BITS_FRAME)) begin
         frame_bits[6'h37 - bit_cnt] <= si;
      end
      // The counter clears at frame end, so the core reads this copy
      if (!cs_n) begin
         frame_len_reg <= bit_cnt + 6'h01;
      end
   end

   // Choose the byte for status and register reads
   always_comb begin
      rd_byte = 8'h00;
      send_now = 1'b0;
      case (link_op)
         fram_status_protect_pkg::OP_STATUS_ONE_READ: begin
            rd_byte = snap_reg[0];
            send_now = (bit_cnt >= fram_status_protect_pkg::BITS_OPCODE);
         end
         fram_status_protect_pkg::OP_STATUS_TWO_READ: begin
            rd_byte = snap_reg[1];
            send_now = (bit_cnt >= fram_status_protect_pkg::BITS_OPCODE);
         end
         fram_status_protect_pkg::OP_ANY_REG_READ: begin
            // Either space returns the same volatile image
            if (reg_addr_ok(frame_bits[47:24])) begin
               rd_byte = snap_reg[frame_bits[26:24]];
            end
            send_now = (bit_cnt >= fram_status_protect_pkg::BITS_OP_ADDR);
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // Data goes out on the falling edge, most significant bit first
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         so_oe <= send_now;
         so <= send_now & rd_byte[3'h7 - bit_phase];
      end
   end

   // ---------------- Core domain (clk) ----------------
   logic cs_meta, cs_sync, cs_last; // Frame end crossing
   logic wp_meta, wp_sync; // Write-protect pin
   logic hwr_meta, hwr_sync; // Hardware reset pin
   logic frame_end; // One-cycle pulse, two cycles after chip select rises
   logic hw_reset; // Hardware reset pin held low
   logic any_reset; // Power-on, hardware, or software reset
   logic soft_reset; // Reset command after reset-enable
   logic reset_armed_reg; // Last command was reset-enable
   logic wel_reg; // Write-enable latch
   logic crc_abort_reg; // Last CRC request was refused
   logic [7:0] vol_reg [0:fram_status_protect_pkg::SLOTS-1]; // Working copies
   logic [7:0] nv_reg [0:fram_status_protect_pkg::SLOTS-1]; // Retained copies
   fram_status_protect_pkg::crc_state_t crc_state_reg;
   logic [7:0] op;
   logic [23:0] addr;
   logic [23:0] end_addr;
   logic [7:0] status_data; // Data byte of a status write
   logic [7:0] frame_data; // Data byte after opcode and address
   logic busy;
   logic cmd_allowed;
   logic lock_active;
   logic have_op, have_byte, have_addr_byte, have_full;
   logic status_wr_go, reg_wr_go, reg_wr_nv;
   logic [7:0] sr1_image, sr2_image;

   // Two flip-flops for the chip select, write-protect and hardware reset levels
   always_ff @(posedge clk) begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_last <= cs_sync;
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
      hwr_meta <= hw_reset_n;
      hwr_sync <= hwr_meta;
   end

   // The frame bits are static once chip select is high and sck has stopped
   assign frame_end = ce & cs_sync & ~cs_last;
   assign op = frame_bits[55:48];
   assign addr = frame_bits[47:24];
   assign end_addr = frame_bits[23:0];
   assign status_data = frame_bits[47:40];
   assign frame_data = frame_bits[23:16];
   assign have_op = (frame_len_reg >= fram_status_protect_pkg::BITS_OPCODE);
   assign have_byte = (frame_len_reg >= fram_status_protect_pkg::BITS_OP_BYTE);
   assign have_addr_byte = (frame_len_reg >= fram_status_protect_pkg::BITS_OP_ADDR_BYTE);
   assign have_full = (frame_len_reg >= fram_status_protect_pkg::BITS_FRAME);

   assign busy = crc_state_reg[fram_status_protect_pkg::CRC_RUN_BIT];
   assign hw_reset = ~hwr_sync;
   assign any_reset = ~reset_n | hw_reset | soft_reset;
   assign lock_active = vol_reg[0][fram_status_protect_pkg::SR1_LOCK_BIT] & ~wp_sync;

   // Only reads, suspend, and the reset pair get through while busy
   always_comb begin
      case (op)
         fram_status_protect_pkg::OP_STATUS_ONE_READ,
         fram_status_protect_pkg::OP_STATUS_TWO_READ,
         fram_status_protect_pkg::OP_ANY_REG_READ,
         fram_status_protect_pkg::OP_CRC_SUSPEND,
         fram_status_protect_pkg::OP_RESET_ENABLE,
         fram_status_protect_pkg::OP_RESET: begin
            cmd_allowed = frame_end & have_op;
         end
         default: begin
            cmd_allowed = frame_end & have_op & ~busy;
         end
      endcase
   end

   assign soft_reset = cmd_allowed & reset_armed_reg & (op == fram_status_protect_pkg::OP_RESET);

   // Register writes need the latch and no lock; otherwise nothing moves
   assign status_wr_go = cmd_allowed & wel_reg & ~lock_active & have_byte &
                         (op == fram_status_protect_pkg::OP_STATUS_WRITE);
   assign reg_wr_go = cmd_allowed & wel_reg & ~lock_active & have_addr_byte &
                      (op == fram_status_protect_pkg::OP_ANY_REG_WRITE) &
                      reg_addr_ok(addr);
   assign reg_wr_nv = (addr[23:16] == fram_status_protect_pkg::REG_SPACE_NV);

   // Reset-enable arms the next command only
   always_ff @(posedge clk) begin
      if (any_reset) begin
         reset_armed_reg <= 1'b0;
      end else if (cmd_allowed) begin
         reset_armed_reg <= (op == fram_status_protect_pkg::OP_RESET_ENABLE);
      end
   end

   // Write-enable latch: one setter, a fixed list of clearers
   always_ff @(posedge clk) begin
      if (any_reset) begin
         wel_reg <= 1'b0;
      end else if (cmd_allowed) begin
         case (op)
            fram_status_protect_pkg::OP_WRITE_ENABLE: begin
               wel_reg <= 1'b1;
            end
            fram_status_protect_pkg::OP_WRITE_DISABLE,
            fram_status_protect_pkg::OP_SPECIAL_SECTOR_WRITE,
            fram_status_protect_pkg::OP_SERIAL_NUMBER_WRITE: begin
               wel_reg <= 1'b0;
            end
            fram_status_protect_pkg::OP_STATUS_WRITE,
            fram_status_protect_pkg::OP_ANY_REG_WRITE: begin
               // A locked register write is ignored whole, latch included
               if (!lock_active) begin
                  wel_reg <= 1'b0;
               end
            end
            default: begin
               wel_reg <= wel_reg; // Array writes keep it set
            end
         endcase
      end
   end

   // Shadowed registers: one working and one retained copy per slot
   generate
      for (genvar s = 0; s < fram_status_protect_pkg::SLOTS; s++) begin : g_slot
         localparam logic [7:0] OFS = fram_status_protect_pkg::SLOT_OFFSET[8*s +: 8];
         localparam logic [7:0] RST = fram_status_protect_pkg::SLOT_RESET[8*s +: 8];
         localparam logic [7:0] MASK = (s == 0) ? fram_status_protect_pkg::SR1_WRITABLE_MASK :
                                                  8'hFF;
         logic hit, to_nv;
         logic [7:0] wdata;
         assign hit = (reg_wr_go && (addr[7:0] == OFS)) || ((s == 0) && status_wr_go);
         assign to_nv = status_wr_go | reg_wr_nv;
         assign wdata = (status_wr_go ? status_data : frame_data) & MASK;
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               nv_reg[s] <= RST;
               vol_reg[s] <= RST;
            end else if (hw_reset) begin
               vol_reg[s] <= nv_reg[s];
            end else if (hit) begin
               vol_reg[s] <= wdata;
               if (to_nv) begin
                  nv_reg[s] <= wdata;
               end
            end
         end
      end
   endgenerate

   // CRC sequencer: busy is the running state alone
   always_ff @(posedge clk) begin
      if (any_reset) begin
         crc_state_reg <= fram_status_protect_pkg::CRC_IDLE;
         crc_abort_reg <= 1'b0;
         crc_start <= 1'b0;
         crc_start_addr <= 24'h000000;
         crc_end_addr <= 24'h000000;
      end else if (ce) begin
         crc_start <= 1'b0;
         case (crc_state_reg)
            fram_status_protect_pkg::CRC_IDLE: begin
               if (cmd_allowed && have_full && (op == fram_status_protect_pkg::OP_CRC_CALCULATE)) begin
                  if ({1'b0, end_addr} < ({1'b0, addr} + fram_status_protect_pkg::CRC_MIN_SPAN)) begin
                     crc_abort_reg <= 1'b1;
                  end else begin
                     crc_abort_reg <= 1'b0;
                     crc_state_reg <= fram_status_protect_pkg::CRC_RUN;
                     crc_start <= 1'b1;
                     crc_start_addr <= addr;
                     crc_end_addr <= end_addr;
                  end
               end
            end
            fram_status_protect_pkg::CRC_RUN: begin
               if (cmd_allowed && (op == fram_status_protect_pkg::OP_CRC_SUSPEND)) begin
                  crc_state_reg <= fram_status_protect_pkg::CRC_SUSPEND;
               end else if (crc_done) begin
                  crc_state_reg <= fram_status_protect_pkg::CRC_IDLE;
               end
            end
            fram_status_protect_pkg::CRC_SUSPEND: begin
               if (cmd_allowed && (op == fram_status_protect_pkg::OP_CRC_RESUME)) begin
                  crc_state_reg <= fram_status_protect_pkg::CRC_RUN;
               end
            end
            default: begin
               crc_state_reg <= fram_status_protect_pkg::CRC_IDLE;
            end
         endcase
      end
   end

   // Array write strobe, gated by latch and protected range
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mem_wr_valid <= 1'b0;
         mem_wr_addr <= 19'h00000;
         mem_wr_data <= 8'h00;
      end else if (ce) begin
         mem_wr_valid <= cmd_allowed & wel_reg & have_addr_byte &
                         (op == fram_status_protect_pkg::OP_MEMORY_WRITE) &
                         ~block_protected(addr[18:0],
                            vol_reg[0][fram_status_protect_pkg::SR1_BP_LSB +: 3],
                            vol_reg[0][fram_status_protect_pkg::SR1_ORIGIN_BIT]);
         mem_wr_addr <= addr[18:0];
         mem_wr_data <= frame_data;
      end
   end

   // Status images built from live state
   always_comb begin
      sr1_image = vol_reg[0] & fram_status_protect_pkg::SR1_WRITABLE_MASK;
      sr1_image[fram_status_protect_pkg::SR1_WEL_BIT] = wel_reg;
      sr1_image[fram_status_protect_pkg::SR1_BUSY_BIT] = busy;
      sr2_image = 8'h00;
      sr2_image[fram_status_protect_pkg::SR2_SUSPEND_BIT] =
         crc_state_reg[fram_status_protect_pkg::CRC_SUSPEND_BIT];
      sr2_image[fram_status_protect_pkg::SR2_ABORT_BIT] = crc_abort_reg;
   end

   // Snapshot only between frames, so the link reads a steady value;
   // a frame needs eight sck periods before its first read bit, far longer
   // than the two-cycle crossing delay of chip select
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i <= 6; i++) begin
            snap_reg[i] <= 8'h00;
         end
      end else if (ce && cs_sync) begin
         snap_reg[0] <= sr1_image;
         snap_reg[1] <= sr2_image;
         snap_reg[2] <= vol_reg[1];
         snap_reg[3] <= vol_reg[2];
         snap_reg[4] <= 8'h00;
         snap_reg[5] <= vol_reg[3];
         snap_reg[6] <= vol_reg[4];
      end
   end

   // Working copies drive the device configuration
   assign config_active = {vol_reg[4], vol_reg[3], vol_reg[2], vol_reg[1]};
   assign crc_run = crc_state_reg[fram_status_protect_pkg::CRC_RUN_BIT];
   assign crc_suspend = crc_state_reg[fram_status_protect_pkg::CRC_SUSPEND_BIT];

endmodule

/* File: testbench/fram_status_protect_regs_monitor.sv */
`timescale 1ns/1ps

// Port-level checks of the status and protection logic, core clock domain
module fram_status_protect_regs_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic mem_wr_valid,
   input wire logic crc_start,
   input wire logic crc_run,
   input wire logic crc_suspend,
   input wire logic [23:0] crc_start_addr,
   input wire logic [23:0] crc_end_addr,
   input wire logic [31:0] config_active
);
   // Array write strobe is a single pulse, the latch is never consumed by it
   a_wr_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
      mem_wr_valid |=> !mem_wr_valid) else $error("array write strobe too long");
   // No array write lands while a calculation runs
   a_busy_blocks_write: assert property (@(posedge clk) disable iff (!reset_n)
      crc_run |-> !mem_wr_valid) else $error("array write while busy");
   // A start is followed by busy in the same cycle or the next
   a_start_sets_busy: assert property (@(posedge clk) disable iff (!reset_n)
      crc_start |-> ##[0:1] crc_run) else $error("start without busy");
   // Busy rises only from a start or a resume out of suspension
   a_busy_has_cause: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(crc_run) |-> crc_start || $past(crc_start) || $past(crc_suspend))
      else $error("busy raised without cause");
   // Running and suspended never coexist
   a_state_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
      !(crc_run && crc_suspend)) else $error("busy and suspended together");
   // Widened by one bit so a start near the top cannot wrap the sum
   a_crc_span_ok: assert property (@(posedge clk) disable iff (!reset_n)
      crc_start |-> {1'b0, crc_end_addr} >= {1'b0, crc_start_addr} + 25'h0000003)
      else $error("calculation started on too short a range");
   // Power-on reset clears the volatile state
   a_reset_clears_state: assert property (@(posedge clk)
      !reset_n |=> !crc_run && !crc_suspend && !mem_wr_valid && !crc_start)
      else $error("state not cleared by reset");
   a_reset_loads_config: assert property (@(posedge clk)
      !reset_n |=> config_active == 32'h00000000) else $error("config not reloaded");
   // Output stays released while the link is idle
   a_link_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      cs_n && $past(cs_n) |-> !so_oe) else $error("output driven while deselected");
endmodule

bind fram_status_protect_regs fram_status_protect_regs_monitor i_fram_status_protect_regs_monitor (
   .clk(clk),
   .reset_n(reset_n),
   .cs_n(cs_n),
   .so_oe(so_oe),
   .mem_wr_valid(mem_wr_valid),
   .crc_start(crc_start),
   .crc_run(crc_run),
   .crc_suspend(crc_suspend),
   .crc_start_addr(crc_start_addr),
   .crc_end_addr(crc_end_addr),
   .config_active(config_active)
);

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ps

// Serial host: link clock runs only inside frames, mode 0, MSB first
module spi_host_model (
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so,
   input wire logic so_oe
);
   localparam time HALF = 24; // Half of the 48 ns link period
   // Idle: deselected, clock low
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b1;
   end
   // Shift n bits from the top of bits, keep the last byte seen on so
   task automatic frame(input int n, input logic [55:0] bits, output logic [7:0] rd);
      rd = 8'h00;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         si = bits[55-i];
         #HALF sck = 1'b1;
         // Undriven output reads as unknown so a missing answer shows
         rd = {rd[6:0], so_oe ? so : 1'bx};
         #HALF sck = 1'b0;
      end
      #HALF cs_n = 1'b1;
      si = ~si; // Released line does not keep its last value
      #400; // Gap lets the core see and execute the frame end
   endtask
endmodule

/* File: testbench/test_fram_status_protect_regs.sv */
`timescale 1ns/1ps

// Drives serial frames and checks status, strobes and config copies
module test_fram_status_protect_regs;
   logic clk, reset_n, wp_n, hw_reset_n, crc_done, sck, cs_n, si, so, so_oe;
   logic mem_wr_valid, crc_start, crc_run, crc_suspend;
   logic [18:0] mem_wr_addr, wr_last;
   logic [7:0] mem_wr_data, rd;
   logic [23:0] crc_start_addr, crc_end_addr;
   logic [31:0] config_active;
   logic [19:0] size, prot;
   int errors = 0;
   int tests_run = 0;
   int wr_count = 0;
   int cycles = 0;
   // Core clock, 50 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   fram_status_protect_regs i_fram_status_protect_regs (.clk(clk), .reset_n(reset_n),
      .ce(1'b1), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
      .hw_reset_n(hw_reset_n), .crc_done(crc_done), .mem_wr_valid(mem_wr_valid),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .crc_start(crc_start),
      .crc_run(crc_run), .crc_suspend(crc_suspend), .crc_start_addr(crc_start_addr),
      .crc_end_addr(crc_end_addr), .config_active(config_active));
   spi_host_model i_spi_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
   // Counts permitted array writes; also cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (mem_wr_valid === 1'b1) begin
         wr_count <= wr_count + 1;
         wr_last <= mem_wr_addr;
      end
      if (cycles == 40000) begin
         errors = errors + 1;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      i_spi_host_model.frame(8, {op, 48'h0}, rd);
   endtask
   task automatic write_enable_cmd();
      cmd(fram_status_protect_pkg::OP_WRITE_ENABLE);
   endtask
   task automatic sr_write(input logic [7:0] v);
      i_spi_host_model.frame(16, {fram_status_protect_pkg::OP_STATUS_WRITE, v, 40'h0}, rd);
   endtask
   task automatic status(input logic [7:0] op, input logic [7:0] exp);
      i_spi_host_model.frame(16, {op, 48'h0}, rd);
      check(rd, exp);
   endtask
   task automatic any_register_write_cmd(input logic [23:0] a, input logic [7:0] v);
      i_spi_host_model.frame(40, {fram_status_protect_pkg::OP_ANY_REG_WRITE, a, v, 16'h0}, rd);
   endtask
   task automatic any_register_read_cmd(input logic [23:0] a, input logic [7:0] exp);
      i_spi_host_model.frame(40, {fram_status_protect_pkg::OP_ANY_REG_READ, a, 24'h0}, rd);
      check(rd, exp);
   endtask
   // Array write; exp tells whether a strobe should appear
   task automatic mem_write(input logic [19:0] a, input int exp);
      int n;
      n = wr_count;
      i_spi_host_model.frame(40, {fram_status_protect_pkg::OP_MEMORY_WRITE, 4'h0, a, 24'hA50000}, rd);
      check(wr_count - n, exp);
      if (exp == 1) check(wr_last, a[18:0]);
   endtask
   task automatic crc_calculate_cmd(input logic [23:0] sa, input logic [23:0] ea);
      i_spi_host_model.frame(56, {fram_status_protect_pkg::OP_CRC_CALCULATE, sa, ea}, rd);
   endtask
   task automatic soft_reset();
      cmd(fram_status_protect_pkg::OP_RESET_ENABLE);
      cmd(fram_status_protect_pkg::OP_RESET);
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      wp_n = 1'b1;
      hw_reset_n = 1'b1;
      crc_done = 1'b0;
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      status(8'h05, 8'h00);
      sr_write(8'h1C);
      status(8'h05, 8'h00);
      mem_write(20'h7FFFF, 0);
      write_enable_cmd();
      status(8'h05, 8'h02);
      mem_write(20'h7FFFF, 1);
      status(8'h05, 8'h02);
      cmd(fram_status_protect_pkg::OP_WRITE_DISABLE);
      status(8'h05, 8'h00);
      // Every nonzero protect code from both origins, at the range boundary
      for (int o = 0; o < 2; o++) begin
         for (int c = 1; c < 8; c++) begin
            size = (c == 7) ? 20'h80000 : (20'h80000 >> (7 - c));
            prot = o ? size - 20'h1 : 20'h80000 - size;
            write_enable_cmd();
            sr_write({2'b00, o[0], c[2:0], 2'b00});
            write_enable_cmd();
            status(8'h05, {2'b00, o[0], c[2:0], 2'b10});
            mem_write(prot, 0);
            if (c < 7) mem_write(o ? size : prot - 20'h1, 1);
         end
      end
      write_enable_cmd();
      sr_write(8'h80);
      status(8'h05, 8'h80);
      @(posedge clk);
      #1 wp_n = 1'b0;
      write_enable_cmd();
      sr_write(8'h00);
      status(8'h05, 8'h82);
      any_register_write_cmd(24'h070002, 8'h11);
      check(config_active, 32'h0);
      @(posedge clk);
      #1 wp_n = 1'b1;
      sr_write(8'h00);
      status(8'h05, 8'h00);
      write_enable_cmd();
      any_register_write_cmd(24'h070002, 8'h5A);
      check(config_active, 32'h5A);
      any_register_read_cmd(24'h000002, 8'h5A);
      write_enable_cmd();
      any_register_write_cmd(24'h000003, 8'h33);
      check(config_active, 32'h335A);
      any_register_read_cmd(24'h070003, 8'h33);
      write_enable_cmd();
      any_register_write_cmd(24'h070001, 8'hFF);
      any_register_read_cmd(24'h000001, 8'h00);
      @(posedge clk);
      #1 hw_reset_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 hw_reset_n = 1'b1;
      repeat (8) @(posedge clk);
      check(config_active, 32'h3300);
      status(8'h05, 8'h00);
      crc_calculate_cmd(24'h000010, 24'h000012);
      status(8'h07, 8'h08);
      crc_calculate_cmd(24'h000010, 24'h000013);
      check(crc_run, 1);
      status(8'h07, 8'h00);
      write_enable_cmd();
      status(8'h05, 8'h01);
      cmd(fram_status_protect_pkg::OP_CRC_SUSPEND);
      status(8'h07, 8'h10);
      cmd(fram_status_protect_pkg::OP_CRC_RESUME);
      status(8'h07, 8'h00);
      @(posedge clk);
      #1 crc_done = 1'b1;
      @(posedge clk);
      #1 crc_done = 1'b0;
      repeat (2) @(posedge clk);
      check(crc_run, 0);
      crc_calculate_cmd(24'h000010, 24'h000013);
      cmd(fram_status_protect_pkg::OP_CRC_SUSPEND);
      soft_reset();
      status(8'h07, 8'h00);
      crc_calculate_cmd(24'h000020, 24'h000001);
      status(8'h07, 8'h08);
      soft_reset();
      status(8'h07, 8'h00);
      finish_test();
   end
endmodule
